// ===== hdl/btc_pkg.sv
// shared types and constants of the backplane transceiver control block
// assumes a single clock, the backplane clock, with a synchronous reset
package btc_pkg;

    // byte lane 3 width and the remaining address bits (23..19, 2..0)
    localparam int LANE_W = 8;
    localparam int REM_W  = 8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OWN_START,
        ST_OWN_WAIT,
        ST_OWN_HOLD,
        ST_TGT_WAIT,
        ST_TGT_ACK
    } btc_state_t;

    // strobes towards the external address/data transceivers
    typedef struct packed {
        logic captured_addr_out_enable_n;
        logic address_capture_clock;
        logic data_capture_clock;
        logic data_drive_enable_n;
        logic low_half_input_enable;
        logic high_half_input_enable;
        logic start_cycle_active;
    } btc_xcvr_t;

    // backplane start and acknowledge strobes, each with its enable
    typedef struct packed {
        logic start_n;
        logic start_oe_n;
        logic ack_n;
        logic ack_oe_n;
    } btc_ctl_t;

    localparam btc_xcvr_t XCVR_RST = '{
        captured_addr_out_enable_n: 1'b1,
        address_capture_clock:      1'b0,
        data_capture_clock:         1'b0,
        data_drive_enable_n:        1'b1,
        low_half_input_enable:      1'b0,
        high_half_input_enable:     1'b0,
        start_cycle_active:         1'b0
    };

    localparam btc_ctl_t CTL_RST = '{
        start_n:    1'b1,
        start_oe_n: 1'b1,
        ack_n:      1'b1,
        ack_oe_n:   1'b1
    };

    localparam logic OE_N_OFF = 1'b1;

endpackage : btc_pkg

// ===== hdl/btc_cap.sv
// load-enabled holding register for one group of directly carried lines
// assumes d is stable in the cycle in which load is high
`timescale 1ns/1ps
module btc_cap #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         load,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] next_q;

    always_comb begin
        next_q = load ? d : q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

endmodule : btc_cap

// ===== hdl/btc_ctrl.sv
// strobe generator for the backplane address/data transceivers
// assumes every input is synchronous to clk, the backplane clock, and that
// the sequencer decodes transfer mode and tells the target direction
`timescale 1ns/1ps
module btc_ctrl #(
    parameter int LANE_W = btc_pkg::LANE_W,
    parameter int REM_W  = btc_pkg::REM_W
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              own_req,
    input  wire logic              own_write,
    input  wire logic              tgt_write,
    input  wire logic              tgt_done,
    output logic                   busy,
    input  wire logic              bp_start_n_in,
    input  wire logic              bp_ack_n_in,
    output btc_pkg::btc_ctl_t      bp_ctl,
    output btc_pkg::btc_xcvr_t     xcvr,
    input  wire logic [LANE_W-1:0] bp_lane3_in,
    output logic      [LANE_W-1:0] bp_lane3_out,
    output logic                   bp_lane3_oe_n,
    input  wire logic [LANE_W-1:0] loc_lane_in,
    output logic      [LANE_W-1:0] loc_lane_out,
    output logic                   loc_lane_oe_n,
    input  wire logic [REM_W-1:0]  bp_rem_in,
    output logic      [REM_W-1:0]  bp_rem_out,
    output logic                   bp_rem_oe_n,
    input  wire logic [REM_W-1:0]  loc_rem_in,
    output logic      [REM_W-1:0]  loc_rem_out,
    output logic                   loc_rem_oe_n
);

    ////////////////////////////////////////////////////////////////////////
    // sequencing state

    btc_pkg::btc_state_t state;
    btc_pkg::btc_state_t next_state;
    logic                dir_wr;
    logic                next_dir_wr;
    logic                own_go;
    logic                tgt_start;
    logic                bus_start;

    // start with ack low is an attention cycle, not a transfer
    assign bus_start = !bp_start_n_in && bp_ack_n_in;
    assign tgt_start = (state == btc_pkg::ST_IDLE) && bus_start;
    // a foreign start wins over our own request in the same cycle
    assign own_go    = (state == btc_pkg::ST_IDLE) && own_req && bp_start_n_in;
    assign busy      = (state != btc_pkg::ST_IDLE);

    always_comb begin
        next_state  = state;
        next_dir_wr = dir_wr;
        case (state)
            btc_pkg::ST_IDLE: begin
                if (tgt_start) begin
                    next_state  = btc_pkg::ST_TGT_WAIT;
                    next_dir_wr = tgt_write;
                end else if (own_go) begin
                    next_state  = btc_pkg::ST_OWN_START;
                    next_dir_wr = own_write;
                end
            end
            btc_pkg::ST_OWN_START: begin
                next_state = btc_pkg::ST_OWN_WAIT;
            end
            btc_pkg::ST_OWN_WAIT: begin
                if (!bp_ack_n_in) begin
                    next_state = dir_wr ? btc_pkg::ST_IDLE
                                        : btc_pkg::ST_OWN_HOLD;
                end
            end
            btc_pkg::ST_OWN_HOLD: begin
                next_state = btc_pkg::ST_IDLE;
            end
            btc_pkg::ST_TGT_WAIT: begin
                if (tgt_done) begin
                    next_state = btc_pkg::ST_TGT_ACK;
                end
            end
            btc_pkg::ST_TGT_ACK: begin
                next_state = btc_pkg::ST_IDLE;
            end
            default: begin
                next_state = btc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state  <= btc_pkg::ST_IDLE;
            dir_wr <= 1'b0;
        end else begin
            state  <= next_state;
            dir_wr <= next_dir_wr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strobes and drive enables, registered from the next state so that
    // inbound and outbound never overlap even for one cycle

    btc_pkg::btc_xcvr_t next_xcvr;
    btc_pkg::btc_ctl_t  next_ctl;
    logic               next_bp_lane3_oe_n;
    logic               next_loc_lane_oe_n;
    logic               next_bp_rem_oe_n;
    logic               next_loc_rem_oe_n;
    logic               addr_load;
    logic               data_load;
    logic               out_load;
    logic               inbound;

    // sampling of a start, our own included
    assign addr_load = bus_start && (state == btc_pkg::ST_IDLE
                       || state == btc_pkg::ST_OWN_START);
    // data moving toward the local bus: owner read or target write
    assign data_load = (state == btc_pkg::ST_OWN_WAIT && !dir_wr
                        && !bp_ack_n_in)
                     || (state == btc_pkg::ST_TGT_WAIT && dir_wr
                        && tgt_done);
    assign out_load  = (own_go && own_write)
                     || (state == btc_pkg::ST_TGT_WAIT && !dir_wr
                        && tgt_done);
    assign inbound   = (next_state == btc_pkg::ST_OWN_WAIT && !next_dir_wr)
                     || next_state == btc_pkg::ST_OWN_HOLD
                     || ((next_state == btc_pkg::ST_TGT_WAIT
                         || next_state == btc_pkg::ST_TGT_ACK)
                        && next_dir_wr);

    always_comb begin
        next_xcvr = btc_pkg::XCVR_RST;
        next_ctl  = btc_pkg::CTL_RST;
        next_xcvr.address_capture_clock = addr_load;
        next_xcvr.data_capture_clock    = data_load;
        // captured address stays on the local bus for the whole target access,
        // but a read ack drives data outbound, so the address lets go
        next_xcvr.captured_addr_out_enable_n =
            !(next_state == btc_pkg::ST_TGT_WAIT
              || (next_state == btc_pkg::ST_TGT_ACK
                  && next_dir_wr));
        next_xcvr.low_half_input_enable  = inbound;
        next_xcvr.high_half_input_enable = inbound;
        next_xcvr.start_cycle_active =
            (next_state == btc_pkg::ST_OWN_START);
        next_xcvr.data_drive_enable_n =
            !((next_state == btc_pkg::ST_OWN_WAIT && next_dir_wr)
              || (next_state == btc_pkg::ST_TGT_ACK
                  && !next_dir_wr));
        if (next_state == btc_pkg::ST_OWN_START) begin
            next_ctl.start_n    = 1'b0;
            next_ctl.start_oe_n = 1'b0;
        end
        if (next_state == btc_pkg::ST_TGT_ACK) begin
            next_ctl.ack_n    = 1'b0;
            next_ctl.ack_oe_n = 1'b0;
        end
        next_bp_lane3_oe_n = next_xcvr.data_drive_enable_n;
        next_loc_lane_oe_n = !inbound;
        next_bp_rem_oe_n   = !next_xcvr.start_cycle_active;
        next_loc_rem_oe_n  = next_xcvr.captured_addr_out_enable_n;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            xcvr          <= btc_pkg::XCVR_RST;
            bp_ctl        <= btc_pkg::CTL_RST;
            bp_lane3_oe_n <= btc_pkg::OE_N_OFF;
            loc_lane_oe_n <= btc_pkg::OE_N_OFF;
            bp_rem_oe_n   <= btc_pkg::OE_N_OFF;
            loc_rem_oe_n  <= btc_pkg::OE_N_OFF;
        end else begin
            xcvr          <= next_xcvr;
            bp_ctl        <= next_ctl;
            bp_lane3_oe_n <= next_bp_lane3_oe_n;
            loc_lane_oe_n <= next_loc_lane_oe_n;
            bp_rem_oe_n   <= next_bp_rem_oe_n;
            loc_rem_oe_n  <= next_loc_rem_oe_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // directly carried lines: byte lane 3 and the address remainder

    btc_cap #(.W(REM_W)) u_rem_in (
        .clk  (clk),
        .srst (srst),
        .load (addr_load),
        .d    (bp_rem_in),
        .q    (loc_rem_out)
    );

    btc_cap #(.W(REM_W)) u_rem_out (
        .clk  (clk),
        .srst (srst),
        .load (own_go),
        .d    (loc_rem_in),
        .q    (bp_rem_out)
    );

    btc_cap #(.W(LANE_W)) u_lane_in (
        .clk  (clk),
        .srst (srst),
        .load (data_load),
        .d    (bp_lane3_in),
        .q    (loc_lane_out)
    );

    btc_cap #(.W(LANE_W)) u_lane_out (
        .clk  (clk),
        .srst (srst),
        .load (out_load),
        .d    (loc_lane_in),
        .q    (bp_lane3_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_own_go;
        own_go;
    endsequence

    sequence s_start_slot;
        xcvr.start_cycle_active && !bp_ctl.start_n && !bp_ctl.start_oe_n
            && !bp_rem_oe_n;
    endsequence

    sequence s_start_gone;
        !xcvr.start_cycle_active && bp_ctl.start_oe_n && bp_rem_oe_n;
    endsequence

    sequence s_tgt_done_rd;
        state == btc_pkg::ST_TGT_WAIT && !dir_wr && tgt_done;
    endsequence

    a_addr_out_en: assert property (
        tgt_start |=> !xcvr.captured_addr_out_enable_n && !loc_rem_oe_n
    ) else $error("captured address not enabled onto local bus");

    a_addr_cap_pulse: assert property (
        tgt_start |=> xcvr.address_capture_clock
                      ##1 !xcvr.address_capture_clock
    ) else $error("address capture clock not a single pulse");

    a_data_cap_read: assert property (
        (state == btc_pkg::ST_OWN_WAIT && !dir_wr && !bp_ack_n_in)
        |=> xcvr.data_capture_clock && xcvr.low_half_input_enable
            && loc_lane_out == $past(bp_lane3_in)
    ) else $error("owner read data not captured");

    a_data_cap_write: assert property (
        (state == btc_pkg::ST_TGT_WAIT && dir_wr && tgt_done)
        |=> xcvr.data_capture_clock && !bp_ctl.ack_n
    ) else $error("target write data not captured");

    a_read_data_out: assert property (
        s_tgt_done_rd |=> !xcvr.data_drive_enable_n && !bp_lane3_oe_n
            && bp_lane3_out == $past(loc_lane_in)
    ) else $error("target read data not driven");

    a_halves_together: assert property (
        xcvr.low_half_input_enable == xcvr.high_half_input_enable
        && xcvr.low_half_input_enable == !loc_lane_oe_n
    ) else $error("inbound lane enables disagree");

    a_own_start: assert property (
        s_own_go |=> s_start_slot ##1 s_start_gone
    ) else $error("own start cycle not exactly one clock");

    a_rem_capture: assert property (
        tgt_start |=> loc_rem_out == $past(bp_rem_in)
    ) else $error("address remainder not captured");

    a_ack_one_clk: assert property (
        (state == btc_pkg::ST_TGT_WAIT && tgt_done)
        |=> (!bp_ctl.ack_n && !bp_ctl.ack_oe_n) ##1 bp_ctl.ack_oe_n
    ) else $error("acknowledge not one clock");

    a_no_contention: assert property (
        (!xcvr.data_drive_enable_n || xcvr.start_cycle_active)
        |-> !xcvr.low_half_input_enable && !xcvr.high_half_input_enable
            && xcvr.captured_addr_out_enable_n && loc_lane_oe_n
    ) else $error("outbound and inbound enabled together");

endmodule : btc_ctrl

// ===== verif/btc_xcvr_model.sv
// behavioural model of the external address/data transceivers
// assumes the strobes come straight from the controller's transceiver struct
`timescale 1ns/1ps
module btc_xcvr_model (
    input  wire btc_pkg::btc_xcvr_t xcvr,
    input  wire logic [15:0]        bp_addr_mid,
    output logic      [15:0]        loc_addr_mid,
    output logic                    clash
);
    logic [15:0] held;

    initial held = 16'h0000;

    // only address bits 18..3 pass through these parts
    always @(posedge xcvr.address_capture_clock) held = bp_addr_mid;

    // released bus shows the inverse, so a stale value never passes
    assign loc_addr_mid = xcvr.captured_addr_out_enable_n ? ~held : held;

    // both directions enabled at once would fight inside the parts
    assign clash = (~xcvr.data_drive_enable_n | xcvr.start_cycle_active)
                 & (xcvr.low_half_input_enable | xcvr.high_half_input_enable);
endmodule : btc_xcvr_model

// ===== verif/test_backplane_transceiver_control.sv
// self-checking bench for the transceiver strobe generator
// assumes the bench plays sequencer, backplane and local bus; wires resolved
`timescale 1ns/1ps
module test_backplane_transceiver_control;
    typedef struct {
        bit         own;
        bit         wr;
        int         dly;
        logic [7:0] din;
        logic [7:0] exp;
    } btc_row_t;

    logic               clk = 1'b0;
    logic               srst = 1'b1;
    logic               own_req = 1'b0;
    logic               own_write = 1'b0;
    logic               tgt_write = 1'b0;
    logic               tgt_done = 1'b0;
    logic               ext_start_n = 1'b1;
    logic               ext_ack_n = 1'b1;
    logic [7:0]         ext_lane3 = 8'h00;
    logic [7:0]         ext_loc = 8'h00;
    logic [7:0]         ext_rem = 8'h00;
    logic [7:0]         ext_loc_rem = 8'h00;
    logic [15:0]        bp_addr_mid = 16'h0000;
    logic               busy;
    logic               bp_start_n_in;
    logic               bp_ack_n_in;
    btc_pkg::btc_ctl_t  bp_ctl;
    btc_pkg::btc_xcvr_t xcvr;
    logic [7:0]         bp_lane3_in;
    logic [7:0]         bp_lane3_out;
    logic               bp_lane3_oe_n;
    logic [7:0]         loc_lane_in;
    logic [7:0]         loc_lane_out;
    logic               loc_lane_oe_n;
    logic [7:0]         bp_rem_in;
    logic [7:0]         bp_rem_out;
    logic               bp_rem_oe_n;
    logic [7:0]         loc_rem_in;
    logic [7:0]         loc_rem_out;
    logic               loc_rem_oe_n;
    logic [15:0]        loc_addr_mid;
    logic               clash;
    int                 err_total = 0;
    int                 cmp_count = 0;
    btc_row_t           rows [4] = '{'{1'b1, 1'b1, 0, 8'h5a, 8'h5a},
                                     '{1'b1, 1'b0, 2, 8'h3c, 8'h3c},
                                     '{1'b0, 1'b1, 0, 8'he1, 8'he1},
                                     '{1'b0, 1'b0, 3, 8'h7e, 8'h7e}};

    always #5 clk = ~clk;

    // each shared wire follows whoever has its enable low
    assign bp_start_n_in = bp_ctl.start_oe_n ? ext_start_n : bp_ctl.start_n;
    assign bp_ack_n_in   = bp_ctl.ack_oe_n ? ext_ack_n : bp_ctl.ack_n;
    assign bp_lane3_in   = bp_lane3_oe_n ? ext_lane3 : bp_lane3_out;
    assign loc_lane_in   = loc_lane_oe_n ? ext_loc : loc_lane_out;
    assign bp_rem_in     = bp_rem_oe_n ? ext_rem : bp_rem_out;
    assign loc_rem_in    = loc_rem_oe_n ? ext_loc_rem : loc_rem_out;

    btc_ctrl btc_ctrl_i (.clk, .srst, .own_req, .own_write, .tgt_write,
        .tgt_done, .busy, .bp_start_n_in, .bp_ack_n_in, .bp_ctl, .xcvr,
        .bp_lane3_in, .bp_lane3_out, .bp_lane3_oe_n, .loc_lane_in,
        .loc_lane_out, .loc_lane_oe_n, .bp_rem_in, .bp_rem_out, .bp_rem_oe_n,
        .loc_rem_in, .loc_rem_out, .loc_rem_oe_n);

    btc_xcvr_model btc_xcvr_model_i (.xcvr, .bp_addr_mid, .loc_addr_mid,
        .clash);

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_flag(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_flag

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////
    task automatic own_xfer(input bit wr, input int dly, input logic [7:0] din,
                            input logic [7:0] exp);
        own_req = 1'b1;
        own_write = wr;
        ext_loc = din;
        ext_loc_rem = 8'hc3;
        @(negedge clk);
        own_req = 1'b0;
        ext_loc = ~din;
        ext_loc_rem = 8'h00;
        chk_flag(xcvr.start_cycle_active, 1'b1);
        chk_flag(bp_ctl.start_n, 1'b0);
        chk_flag(bp_ctl.start_oe_n, 1'b0);
        chk_val(bp_rem_out, 8'hc3);
        chk_flag(bp_rem_oe_n, 1'b0);
        @(negedge clk);
        chk_flag(bp_ctl.start_n, 1'b1);
        chk_flag(xcvr.start_cycle_active, 1'b0);
        chk_flag(xcvr.address_capture_clock, 1'b1);
        chk_flag(xcvr.data_drive_enable_n, !wr);
        chk_flag(xcvr.low_half_input_enable, !wr);
        chk_flag(xcvr.high_half_input_enable, !wr);
        chk_flag(bp_lane3_oe_n, !wr);
        chk_flag(loc_lane_oe_n, wr);
        if (wr) chk_val(bp_lane3_out, exp);
        repeat (dly) @(negedge clk);
        // target answers with a one-clock acknowledge
        ext_ack_n = 1'b0;
        ext_lane3 = din;
        @(negedge clk);
        ext_ack_n = 1'b1;
        ext_lane3 = ~din;
        chk_flag(xcvr.data_capture_clock, !wr);
        if (!wr) begin
            chk_val(loc_lane_out, exp);
            @(negedge clk);
        end
        chk_flag(busy, 1'b0);
        chk_flag(xcvr.data_drive_enable_n, 1'b1);
        chk_flag(xcvr.low_half_input_enable, 1'b0);
        $display("owner transfer done, write %0d", wr);
    endtask : own_xfer

    task automatic tgt_xfer(input bit wr, input int dly, input logic [7:0] din,
                            input logic [7:0] exp);
        ext_start_n = 1'b0;
        tgt_write = wr;
        ext_rem = 8'h96;
        bp_addr_mid = 16'h5aa5;
        ext_lane3 = din;
        ext_loc = din;
        @(negedge clk);
        ext_start_n = 1'b1;
        own_req = 1'b0;
        ext_rem = 8'h00;
        bp_addr_mid = 16'h0000;
        chk_flag(xcvr.start_cycle_active, 1'b0);
        chk_flag(xcvr.address_capture_clock, 1'b1);
        chk_flag(xcvr.captured_addr_out_enable_n, 1'b0);
        chk_val(loc_addr_mid, 16'h5aa5);
        chk_val(loc_rem_out, 8'h96);
        chk_flag(loc_rem_oe_n, 1'b0);
        chk_flag(xcvr.low_half_input_enable, wr);
        chk_flag(xcvr.high_half_input_enable, wr);
        repeat (dly) @(negedge clk);
        tgt_done = 1'b1;
        @(negedge clk);
        tgt_done = 1'b0;
        ext_lane3 = ~din;
        ext_loc = ~din;
        chk_flag(bp_ctl.ack_n, 1'b0);
        chk_flag(bp_ctl.ack_oe_n, 1'b0);
        chk_flag(xcvr.address_capture_clock, 1'b0);
        chk_flag(xcvr.data_capture_clock, wr);
        chk_flag(xcvr.data_drive_enable_n, wr);
        chk_flag(xcvr.captured_addr_out_enable_n, !wr);
        chk_flag(loc_lane_oe_n, !wr);
        chk_val(wr ? loc_lane_out : bp_lane3_out, exp);
        @(negedge clk);
        chk_flag(bp_ctl.ack_n, 1'b1);
        chk_flag(xcvr.captured_addr_out_enable_n, 1'b1);
        chk_flag(busy, 1'b0);
        $display("target transfer done, write %0d", wr);
    endtask : tgt_xfer

    ////////////////////////////////////////////////////////////////////////
    always @(negedge clk) if (!srst) chk_flag(clash, 1'b0);

    // whole run is a few dozen cycles; this leaves wide margin
    initial begin
        #20000;
        err_total++;
        tally_and_finish();
    end

    initial begin
        repeat (5) @(negedge clk);
        chk_val({5'h00, xcvr, bp_ctl},
                {5'h00, btc_pkg::XCVR_RST, btc_pkg::CTL_RST});
        srst = 1'b0;
        foreach (rows[i]) begin
            if (rows[i].own) own_xfer(rows[i].wr, rows[i].dly, rows[i].din,
                                      rows[i].exp);
            else tgt_xfer(rows[i].wr, rows[i].dly, rows[i].din, rows[i].exp);
        end
        // start together with ack is not a transfer
        ext_start_n = 1'b0;
        ext_ack_n = 1'b0;
        @(negedge clk);
        ext_start_n = 1'b1;
        ext_ack_n = 1'b1;
        chk_flag(busy, 1'b0);
        chk_flag(xcvr.address_capture_clock, 1'b0);
        $display("attention cycle test done");
        // own request against an incoming start: the target side wins
        own_req = 1'b1;
        own_write = 1'b1;
        tgt_xfer(1'b1, 1, 8'h42, 8'h42);
        // reset in the middle of an owner transfer
        own_req = 1'b1;
        @(negedge clk);
        own_req = 1'b0;
        srst = 1'b1;
        @(negedge clk);
        chk_val({5'h00, xcvr, bp_ctl},
                {5'h00, btc_pkg::XCVR_RST, btc_pkg::CTL_RST});
        chk_flag(busy, 1'b0);
        srst = 1'b0;
        $display("mid-run reset test done");
        own_xfer(1'b0, 0, 8'h99, 8'h99);
        tally_and_finish();
    end
endmodule : test_backplane_transceiver_control
